/* File: core/cilc_pkg.sv */
// Contract
// - three independent input lines, each with its own conditioning path
// - each line's debouncer accepts a level only after it held that long
// - debounce time is set in microseconds, zero to about one second
// - software selects a line first; a debounce write affects that line only
// - per-line inversion, written for the selected line, flips that line
// - any line may source acquisition, frame, line start and encoder A/B
// - reset routing: line start and phase a line 1, phase b 2, frame 3
// - one line may drive several functions at once
// - per-line termination enable switches the 120 ohm bus terminator
package cilc_pkg;
    localparam int          NUM_LINES      = 3;
    localparam int          CLK_MHZ        = 100;
    localparam int          TIME_US        = 1;
    localparam int          US_CYCLES      = CLK_MHZ * TIME_US;
    localparam int          US_W           = 7;
    localparam int          DEB_W          = 20;
    localparam logic [19:0] DEB_MAX_US     = 20'hf4240;
    localparam logic [31:0] ADDR_SEL       = 32'h0000_0000;
    localparam logic [31:0] ADDR_DEB       = 32'h0000_0004;
    localparam logic [31:0] ADDR_CFG       = 32'h0000_0008;
    localparam logic [31:0] ADDR_ROUTE     = 32'h0000_000c;
    localparam logic [31:0] ADDR_STATUS    = 32'h0000_0010;
    localparam int          CFG_INV_BIT    = 0;
    localparam int          CFG_TERM_BIT   = 1;
    localparam int          RT_ACQ_LSB     = 0;
    localparam int          RT_FRM_LSB     = 4;
    localparam int          RT_LIN_LSB     = 8;
    localparam int          RT_PHA_LSB     = 12;
    localparam int          RT_PHB_LSB     = 16;
    localparam int          ST_COND_LSB    = 0;
    localparam int          ST_RAW_LSB     = 4;
    // route codes: 0 none, 1..3 line number
    localparam logic [1:0]  SRC_NONE       = 2'h0;
    localparam logic [1:0]  SRC_LINE1      = 2'h1;
    localparam logic [1:0]  SRC_LINE2      = 2'h2;
    localparam logic [1:0]  SRC_LINE3      = 2'h3;
    localparam logic [1:0]  HTRANS_NONSEQ  = 2'h2;
endpackage

/* File: core/cilc_line_conditioner.sv */
`timescale 1ns/1ps
`default_nettype none
module cilc_line_conditioner
    import cilc_pkg::*;
(
    // clock and reset
    input  wire logic                 hclk,
    input  wire logic                 hresetn,
    // ahb-lite slave
    input  wire logic                 hsel,
    input  wire logic [31:0]          haddr,
    input  wire logic [1:0]           htrans,
    input  wire logic                 hwrite,
    input  wire logic [2:0]           hsize,
    input  wire logic [31:0]          hwdata,
    input  wire logic                 hready,
    output logic      [31:0]          hrdata,
    output logic                      hreadyout,
    output logic                      hresp,
    // raw input lines after receivers
    input  wire logic [NUM_LINES-1:0] line_in,
    // per-line terminator control
    output logic      [NUM_LINES-1:0] bus_terminator,
    // routed function inputs
    output logic                      acq_start_trig,
    output logic                      frame_start_trig,
    output logic                      line_start_trig,
    output logic                      enc_phase_a,
    output logic                      enc_phase_b
);
    logic [1:0]             line_index_select_reg;
    logic [DEB_W-1:0]       glitch_filter_time_us_reg [NUM_LINES];
    logic [NUM_LINES-1:0]   polarity_invert_reg;
    logic [NUM_LINES-1:0]   termination_enable_reg;
    logic [1:0]             src_acq_reg, src_frm_reg, src_lin_reg, src_pha_reg, src_phb_reg;
    logic [NUM_LINES-1:0]   sync1_reg, sync2_reg, stable_reg, cond_reg;
    logic [DEB_W-1:0]       cnt_reg [NUM_LINES];
    logic [US_W-1:0]        us_cnt_reg;
    logic                   us_tick_reg;
    logic                   wr_pend_reg;
    logic [31:0]            wr_addr_reg;
    logic [31:0]            rdata_next;
    logic                   addr_ok;
    logic [1:0]             sel_idx;
    localparam int          TICK_GAP = US_CYCLES;

    assign addr_ok = hsel && hready && htrans == HTRANS_NONSEQ;
    // selector values outside 1..3 map to line 1 so writes never fall off the end
    assign sel_idx = (line_index_select_reg == SRC_NONE) ? 2'h0 : line_index_select_reg - 2'h1;

    // zero-wait slave, write data captured in the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 32'h0000_0000;
        end else begin
            wr_pend_reg <= addr_ok && hwrite;
            wr_addr_reg <= haddr;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            line_index_select_reg  <= SRC_LINE1;
            polarity_invert_reg    <= '0;
            termination_enable_reg <= '0;
            for (int i = 0; i < NUM_LINES; i++) begin
                glitch_filter_time_us_reg[i] <= '0;
            end
            src_acq_reg <= SRC_NONE;
            src_lin_reg <= SRC_LINE1;
            src_pha_reg <= SRC_LINE1;
            src_phb_reg <= SRC_LINE2;
            src_frm_reg <= SRC_LINE3;
        end else if (wr_pend_reg) begin
            unique case (wr_addr_reg)
                ADDR_SEL: line_index_select_reg <= hwdata[1:0];
                ADDR_DEB: begin
                    // clamp to about one second
                    glitch_filter_time_us_reg[sel_idx] <= (hwdata[DEB_W-1:0] > DEB_MAX_US) ?
                        DEB_MAX_US : hwdata[DEB_W-1:0];
                end
                ADDR_CFG: begin
                    polarity_invert_reg[sel_idx]    <= hwdata[CFG_INV_BIT];
                    termination_enable_reg[sel_idx] <= hwdata[CFG_TERM_BIT];
                end
                ADDR_ROUTE: begin
                    src_acq_reg <= hwdata[RT_ACQ_LSB +: 2];
                    src_frm_reg <= hwdata[RT_FRM_LSB +: 2];
                    src_lin_reg <= hwdata[RT_LIN_LSB +: 2];
                    src_pha_reg <= hwdata[RT_PHA_LSB +: 2];
                    src_phb_reg <= hwdata[RT_PHB_LSB +: 2];
                end
                default: ;
            endcase
        end
    end

    always_comb begin
        rdata_next = 32'h0000_0000;
        unique case (haddr)
            ADDR_SEL:    rdata_next[1:0] = line_index_select_reg;
            ADDR_DEB:    rdata_next[DEB_W-1:0] = glitch_filter_time_us_reg[sel_idx];
            ADDR_CFG: begin
                rdata_next[CFG_INV_BIT]  = polarity_invert_reg[sel_idx];
                rdata_next[CFG_TERM_BIT] = termination_enable_reg[sel_idx];
            end
            ADDR_ROUTE: begin
                rdata_next[RT_ACQ_LSB +: 2] = src_acq_reg;
                rdata_next[RT_FRM_LSB +: 2] = src_frm_reg;
                rdata_next[RT_LIN_LSB +: 2] = src_lin_reg;
                rdata_next[RT_PHA_LSB +: 2] = src_pha_reg;
                rdata_next[RT_PHB_LSB +: 2] = src_phb_reg;
            end
            ADDR_STATUS: begin
                rdata_next[ST_COND_LSB +: NUM_LINES] = cond_reg;
                rdata_next[ST_RAW_LSB +: NUM_LINES]  = sync2_reg;
            end
            default: ;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata    <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            if (addr_ok && !hwrite) begin
                hrdata <= rdata_next;
            end
        end
    end

    // one-microsecond timebase shared by all lines
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            us_cnt_reg  <= '0;
            us_tick_reg <= 1'b0;
        end else if (us_cnt_reg == US_W'(US_CYCLES - 1)) begin
            us_cnt_reg  <= '0;
            us_tick_reg <= 1'b1;
        end else begin
            us_cnt_reg  <= us_cnt_reg + 1'b1;
            us_tick_reg <= 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
        end else begin
            sync1_reg <= line_in;
            sync2_reg <= sync1_reg;
        end
    end

    // one tick beyond the set count so the hold is never short; it may run up to one us longer
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            stable_reg <= '0;
            for (int i = 0; i < NUM_LINES; i++) begin
                cnt_reg[i] <= '0;
            end
        end else begin
            for (int i = 0; i < NUM_LINES; i++) begin
                if (sync2_reg[i] == stable_reg[i]) begin
                    cnt_reg[i] <= '0;
                end else if (glitch_filter_time_us_reg[i] == '0 || cnt_reg[i] > glitch_filter_time_us_reg[i]) begin
                    stable_reg[i] <= sync2_reg[i];
                    cnt_reg[i]    <= '0;
                end else if (us_tick_reg) begin
                    cnt_reg[i] <= cnt_reg[i] + 1'b1;
                end
            end
        end
    end

    function automatic logic pick(input logic [1:0] src, input logic [NUM_LINES-1:0] v);
        pick = (src == SRC_NONE) ? 1'b0 : v[src - 2'h1];
    endfunction

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cond_reg         <= '0;
            bus_terminator   <= '0;
            acq_start_trig   <= 1'b0;
            frame_start_trig <= 1'b0;
            line_start_trig  <= 1'b0;
            enc_phase_a      <= 1'b0;
            enc_phase_b      <= 1'b0;
        end else begin
            cond_reg         <= stable_reg ^ polarity_invert_reg;
            bus_terminator   <= termination_enable_reg;
            acq_start_trig   <= pick(src_acq_reg, cond_reg);
            frame_start_trig <= pick(src_frm_reg, cond_reg);
            line_start_trig  <= pick(src_lin_reg, cond_reg);
            enc_phase_a      <= pick(src_pha_reg, cond_reg);
            enc_phase_b      <= pick(src_phb_reg, cond_reg);
        end
    end

    // a pulse shorter than the set time never reaches the stable level
    glitch_reject_a: assert property (@(posedge hclk) disable iff (!hresetn)
        $changed(stable_reg[0]) |-> $past(sync2_reg[0]) == stable_reg[0])
        else $error("stable level changed to a value not on the input");

    glitch_short_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (glitch_filter_time_us_reg[1] != '0 && sync2_reg[1] != stable_reg[1] &&
        cnt_reg[1] <= glitch_filter_time_us_reg[1]) |=> $stable(stable_reg[1]))
        else $error("level accepted before the count ran out");

    count_restart_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (sync2_reg[1] == stable_reg[1]) |=> cnt_reg[1] == '0)
        else $error("debounce count not restarted");

    // cycles the synced level of line 2 has differed from its accepted level
    logic [31:0]            diff_cyc_reg;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            diff_cyc_reg <= 32'h0000_0000;
        end else if (sync2_reg[1] == stable_reg[1]) begin
            diff_cyc_reg <= 32'h0000_0000;
        end else begin
            diff_cyc_reg <= diff_cyc_reg + 32'h0000_0001;
        end
    end

    // the hold is measured in clock cycles, independent of the tick phase
    hold_time_a: assert property (@(posedge hclk) disable iff (!hresetn)
        $changed(stable_reg[1]) |-> $past(diff_cyc_reg) >= 32'(glitch_filter_time_us_reg[1]) * US_CYCLES)
        else $error("line 2 level accepted before the set hold time");

    // timebase
    tick_period_a: assert property (@(posedge hclk) disable iff (!hresetn)
        us_tick_reg |-> ##TICK_GAP us_tick_reg)
        else $error("microsecond tick period wrong");

    tick_pulse_a: assert property (@(posedge hclk) disable iff (!hresetn)
        us_tick_reg |=> !us_tick_reg)
        else $error("microsecond tick longer than one cycle");

    invert_path_a: assert property (@(posedge hclk) disable iff (!hresetn)
        cond_reg == ($past(stable_reg) ^ $past(polarity_invert_reg)))
        else $error("conditioned level wrong");

    cfg_select_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (wr_pend_reg && wr_addr_reg == ADDR_CFG && sel_idx != 2'h0) |=> $stable(polarity_invert_reg[0]))
        else $error("inversion write hit unselected line");

    // routing
    route_fanout_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (src_lin_reg == src_pha_reg && $stable(src_lin_reg)) |=> line_start_trig == enc_phase_a)
        else $error("shared line gives different function levels");

    shared_frame_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (src_frm_reg == src_phb_reg) |=> frame_start_trig == enc_phase_b)
        else $error("frame and phase b differ on a shared line");

    route_follow_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (src_frm_reg == SRC_LINE3) |=> frame_start_trig == $past(cond_reg[2]))
        else $error("frame start not following line 3");

    route_none_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (src_acq_reg == SRC_NONE) |=> !acq_start_trig)
        else $error("unrouted acquisition start not low");

    reset_route_a: assert property (@(posedge hclk)
        $rose(hresetn) |-> src_frm_reg == SRC_LINE3 && src_phb_reg == SRC_LINE2)
        else $error("reset routing wrong");

    reset_line_a: assert property (@(posedge hclk)
        $rose(hresetn) |-> src_lin_reg == SRC_LINE1 && src_pha_reg == SRC_LINE1 && src_acq_reg == SRC_NONE)
        else $error("reset routing of line 1 wrong");

    term_follow_a: assert property (@(posedge hclk) disable iff (!hresetn)
        ##1 bus_terminator == $past(termination_enable_reg))
        else $error("terminator not following setting");

    term_select_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (wr_pend_reg && wr_addr_reg == ADDR_CFG && sel_idx != 2'h0) |=> $stable(termination_enable_reg[0]))
        else $error("termination write hit unselected line");

    // per-line settings reach the selected line only
    deb_select_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (wr_pend_reg && wr_addr_reg == ADDR_DEB && sel_idx != 2'h2) |=> $stable(glitch_filter_time_us_reg[2]))
        else $error("debounce write hit unselected line");

    deb_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (wr_pend_reg && wr_addr_reg == ADDR_DEB && sel_idx == 2'h1) |=>
        glitch_filter_time_us_reg[1] == (($past(hwdata[DEB_W-1:0]) > DEB_MAX_US) ?
        DEB_MAX_US : $past(hwdata[DEB_W-1:0])))
        else $error("debounce write not stored on selected line");

    deb_range_a: assert property (@(posedge hclk) disable iff (!hresetn)
        glitch_filter_time_us_reg[0] <= DEB_MAX_US)
        else $error("debounce time above one second");

    sync_path_a: assert property (@(posedge hclk) disable iff (!hresetn)
        sync2_reg == $past(line_in, 2))
        else $error("synchroniser delay wrong");
endmodule
`default_nettype wire

/* File: tb/cilc_trig_src.sv */
`timescale 1ns/1ps
`default_nettype none
module cilc_trig_src
    import cilc_pkg::*;
#(
    parameter logic [NUM_LINES-1:0] TTL_LINES = 3'h4
)
(
    // levels the sources want to put on the lines
    input  wire logic [NUM_LINES-1:0] drive_level,
    // terminator state at the receivers
    input  wire logic [NUM_LINES-1:0] bus_terminator,
    // levels after the receivers
    output logic      [NUM_LINES-1:0] line_in
);
    // differential sources pass their drive level whatever the terminator; a ttl source into a terminated input reads low
    assign line_in = drive_level & ~(TTL_LINES & bus_terminator);
endmodule
`default_nettype wire

/* File: tb/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench
    import cilc_pkg::*;
();
    logic                 hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic [31:0]          haddr, hwdata, hrdata;
    logic [1:0]           htrans;
    logic [2:0]           hsize;
    logic [NUM_LINES-1:0] drive_level, line_in, bus_terminator;
    logic                 acq_start_trig, frame_start_trig, line_start_trig, enc_phase_a, enc_phase_b;
    logic [4:0]           fn;
    int                   failures, n_compared;
    assign fn = {acq_start_trig, frame_start_trig, line_start_trig, enc_phase_a, enc_phase_b};

    cilc_line_conditioner i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .line_in(line_in), .bus_terminator(bus_terminator),
        .acq_start_trig(acq_start_trig), .frame_start_trig(frame_start_trig),
        .line_start_trig(line_start_trig), .enc_phase_a(enc_phase_a), .enc_phase_b(enc_phase_b));
    cilc_trig_src i_src (.drive_level(drive_level), .bus_terminator(bus_terminator), .line_in(line_in));

    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // called just after a rising edge; returns just after the data phase edge
    task automatic ahb(input logic is_wr, input logic [31:0] addr, input logic [31:0] wdata, output logic [31:0] rdata);
        hsel <= 1'b1;
        htrans <= HTRANS_NONSEQ;
        haddr <= addr;
        hwrite <= is_wr;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= wdata;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rdata = hrdata;
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] r;
        ahb(1'b1, a, d, r);
    endtask

    task automatic rd(input logic [31:0] a, output logic [31:0] d);
        ahb(1'b0, a, 32'h0, d);
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge hclk);
    endtask

    task automatic test_defaults();
        logic [31:0] r;
        rd(ADDR_SEL, r);
        check("select", r, 32'h1);
        rd(ADDR_ROUTE, r);
        check("routes", r, 32'h0002_1130);
        check("terminators", {29'h0, bus_terminator}, 32'h0);
        drive_level <= 3'h1;
        cyc(10);
        check("functions", {27'h0, fn}, 32'h6);
        $display("test defaults done");
    endtask

    // sources hold each level far longer than the glitches they are meant to outlast
    task automatic test_debounce();
        logic [31:0] r;
        wr(ADDR_SEL, 32'h2);
        wr(ADDR_DEB, 32'h5);
        drive_level <= 3'h3;
        cyc(3 * US_CYCLES);
        check("phase b early", {31'h0, enc_phase_b}, 32'h0);
        cyc(4 * US_CYCLES);
        check("phase b held", {31'h0, enc_phase_b}, 32'h1);
        drive_level <= 3'h1;
        cyc(3 * US_CYCLES);
        drive_level <= 3'h3;
        cyc(10 * US_CYCLES);
        check("low glitch", {31'h0, enc_phase_b}, 32'h1);
        check("line 1 untouched", {31'h0, line_start_trig}, 32'h1);
        wr(ADDR_SEL, 32'h1);
        rd(ADDR_DEB, r);
        check("line 1 time", r, 32'h0);
        $display("test debounce done");
    endtask

    task automatic test_invert();
        logic [31:0] r;
        wr(ADDR_SEL, 32'h3);
        wr(ADDR_CFG, 32'h1);
        cyc(10);
        check("frame inverted", {31'h0, frame_start_trig}, 32'h1);
        rd(ADDR_STATUS, r);
        check("status", r, 32'h37);
        $display("test invert done");
    endtask

    task automatic test_routing();
        logic [31:0] c;
        drive_level <= 3'h5;
        cyc(10 * US_CYCLES);
        for (c = 0; c < 4; c++) begin
            wr(ADDR_ROUTE, c * 32'h0001_1111);
            cyc(5);
            check("routed", {27'h0, fn}, (c == 1) ? 32'h1f : 32'h0);
        end
        $display("test routing done");
    endtask

    task automatic test_term_and_map();
        logic [31:0] r;
        wr(ADDR_CFG, 32'h3);
        cyc(10);
        check("terminators", {29'h0, bus_terminator}, 32'h4);
        check("dead ttl inverted", {27'h0, fn}, 32'h1f);
        rd(ADDR_CFG, r);
        check("config", r, 32'h3);
        rd(32'h0000_0020, r);
        check("unmapped", r, 32'h0);
        check("response", {31'h0, hresp}, 32'h0);
        wr(ADDR_SEL, 32'h2);
        wr(ADDR_DEB, 32'h000f_ffff);
        rd(ADDR_DEB, r);
        check("time clamp", r, {12'h0, DEB_MAX_US});
        $display("test termination done");
    endtask

    task automatic final_report();
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge hclk);
        failures++;
        final_report();
    end

    initial begin
        hresetn = 1'b0;
        {hsel, hwrite, htrans, haddr, hwdata} = '0;
        hsize = 3'h2;
        drive_level = 3'h0;
        failures = 0;
        n_compared = 0;
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        test_defaults();
        test_debounce();
        test_invert();
        test_routing();
        test_term_and_map();
        final_report();
    end
endmodule
`default_nettype wire
